// file: pkg/led_blink_pkg.sv
// Constants and types shared by the alternating indicator blinker
package led_blink_pkg;

  // Clock rate and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TIMER_DIV       = 512;
  localparam int unsigned FILTER_DIV      = 64;
  localparam int unsigned INTERVAL_MS     = 500;
  localparam int unsigned FILTER_SAMPLES  = 3;
  // Prescaled ticks per interval: 100e6 * 0.5 / 512 = 97656 (rounded down)
  localparam int unsigned INTERVAL_TICKS  = (CLK_HZ / 1000) * INTERVAL_MS / TIMER_DIV;

  // Switch level when pressed (switch pulls the input low)
  localparam logic SWITCH_PRESSED = 1'h0;
  localparam logic SWITCH_RELEASED = 1'h1;

  // Indicator reset values: first lit, second dark
  localparam logic FIRST_RESET  = 1'h1;
  localparam logic SECOND_RESET = 1'h0;

  typedef enum logic [1:0] {
    MODE_SELECT = 2'h0,
    MODE_AUTO   = 2'h1,
    MODE_MANUAL = 2'h2
  } mode_t;

  typedef struct packed {
    logic first_indicator;
    logic second_indicator;
  } indicators_t;

endpackage

// file: design/led_alternate_blinker.sv
// Alternating two-indicator blinker with reset-time mode select
`timescale 1ns/1ps
module led_alternate_blinker #(
  parameter int unsigned TIMER_DIV      = led_blink_pkg::TIMER_DIV,
  parameter int unsigned FILTER_DIV     = led_blink_pkg::FILTER_DIV,
  parameter int unsigned INTERVAL_TICKS = led_blink_pkg::INTERVAL_TICKS
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic user_switch,
  output logic      first_indicator,
  output logic      second_indicator,
  output logic      manual_mode,
  output logic      auto_mode
);

  localparam int PRE_W  = $clog2(TIMER_DIV);
  localparam int FLT_W  = $clog2(FILTER_DIV);
  localparam int CNT_W  = $clog2(INTERVAL_TICKS + 1);

  function automatic logic wrap_at(input logic [31:0] value, input int unsigned limit);
    wrap_at = (value == 32'(limit - 1));
  endfunction

  led_blink_pkg::mode_t       mode;
  led_blink_pkg::mode_t       next_mode;
  led_blink_pkg::indicators_t leds;
  led_blink_pkg::indicators_t next_leds;

  logic [PRE_W-1:0] prescale;
  logic [PRE_W-1:0] next_prescale;
  logic [CNT_W-1:0] compare_timer_zero;
  logic [CNT_W-1:0] next_compare_timer_zero;
  logic [FLT_W-1:0] filter_div;
  logic [FLT_W-1:0] next_filter_div;
  logic [1:0]       sample_hist;
  logic [1:0]       next_sample_hist;
  logic             filtered;
  logic             next_filtered;
  logic             compare_match_event;
  logic             next_compare_match_event;
  logic             switch_event;
  logic             next_switch_event;
  logic             next_manual_mode;
  logic             next_auto_mode;

  // Mode group: chosen on the first edge after reset release, then held
  always_comb begin
    next_mode = mode;
    case (mode)
      led_blink_pkg::MODE_SELECT: begin
        // First clocked cycle after release catches the switch level
        if (user_switch == led_blink_pkg::SWITCH_PRESSED) begin
          next_mode = led_blink_pkg::MODE_MANUAL;
        end else begin
          next_mode = led_blink_pkg::MODE_AUTO;
        end
      end
      led_blink_pkg::MODE_AUTO: begin
        // Only a reset leaves a chosen mode
        next_mode = led_blink_pkg::MODE_AUTO;
      end
      led_blink_pkg::MODE_MANUAL: begin
        next_mode = led_blink_pkg::MODE_MANUAL;
      end
      default: begin
        next_mode = led_blink_pkg::MODE_SELECT;
      end
    endcase
    next_manual_mode = (next_mode == led_blink_pkg::MODE_MANUAL);
    next_auto_mode   = (next_mode == led_blink_pkg::MODE_AUTO);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode        <= led_blink_pkg::MODE_SELECT;
      manual_mode <= 1'h0;
      auto_mode   <= 1'h0;
    end else begin
      mode        <= next_mode;
      manual_mode <= next_manual_mode;
      auto_mode   <= next_auto_mode;
    end
  end

  // Timer group: prescaler and compare counter
  always_comb begin
    logic prescale_tick;
    prescale_tick            = 1'h0;
    next_prescale            = prescale;
    next_compare_timer_zero  = compare_timer_zero;
    next_compare_match_event = 1'h0;
    if (mode == led_blink_pkg::MODE_AUTO) begin
      prescale_tick = wrap_at(32'(prescale), TIMER_DIV);
      next_prescale = prescale_tick ? '0 : PRE_W'(prescale + 1'h1);
      if (prescale_tick) begin
        if (wrap_at(32'(compare_timer_zero), INTERVAL_TICKS)) begin
          next_compare_timer_zero  = '0;
          next_compare_match_event = 1'h1;
        end else begin
          next_compare_timer_zero = CNT_W'(compare_timer_zero + 1'h1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prescale            <= '0;
      compare_timer_zero  <= '0;
      compare_match_event <= 1'h0;
    end else begin
      prescale            <= next_prescale;
      compare_timer_zero  <= next_compare_timer_zero;
      compare_match_event <= next_compare_match_event;
    end
  end

  // Filter group: sampled switch history and press detection
  always_comb begin
    logic filter_tick;
    filter_tick       = 1'h0;
    next_filter_div   = filter_div;
    next_sample_hist  = sample_hist;
    next_filtered     = filtered;
    next_switch_event = 1'h0;
    case (mode)
      led_blink_pkg::MODE_SELECT: begin
        // Filter starts from the level seen at selection so a held press is no edge
        next_filtered    = user_switch;
        next_sample_hist = {user_switch, user_switch};
      end
      led_blink_pkg::MODE_MANUAL: begin
        // Switch path enabled only here
        filter_tick     = wrap_at(32'(filter_div), FILTER_DIV);
        next_filter_div = filter_tick ? '0 : FLT_W'(filter_div + 1'h1);
        if (filter_tick) begin
          next_sample_hist = {sample_hist[0], user_switch};
          if (user_switch == sample_hist[0] && sample_hist[0] == sample_hist[1]) begin
            next_filtered = user_switch;
            if (filtered == led_blink_pkg::SWITCH_RELEASED &&
                user_switch == led_blink_pkg::SWITCH_PRESSED) begin
              next_switch_event = 1'h1;
            end
          end
        end
      end
      default: begin
        // Automatic mode leaves the switch path idle
        next_switch_event = 1'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      filter_div   <= '0;
      sample_hist  <= 2'h3;
      filtered     <= led_blink_pkg::SWITCH_RELEASED;
      switch_event <= 1'h0;
    end else begin
      filter_div   <= next_filter_div;
      sample_hist  <= next_sample_hist;
      filtered     <= next_filtered;
      switch_event <= next_switch_event;
    end
  end

  // Indicator group: each event of the active mode swaps both outputs
  always_comb begin
    next_leds = leds;
    if ((mode == led_blink_pkg::MODE_AUTO && compare_match_event) ||
        (mode == led_blink_pkg::MODE_MANUAL && switch_event)) begin
      next_leds = '{first_indicator: ~leds.first_indicator,
                    second_indicator: ~leds.second_indicator};
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      leds             <= '{first_indicator: led_blink_pkg::FIRST_RESET,
                            second_indicator: led_blink_pkg::SECOND_RESET};
      first_indicator  <= led_blink_pkg::FIRST_RESET;
      second_indicator <= led_blink_pkg::SECOND_RESET;
    end else begin
      leds             <= next_leds;
      // Outputs come straight from flip-flops that track the state copy
      first_indicator  <= next_leds.first_indicator;
      second_indicator <= next_leds.second_indicator;
    end
  end

endmodule

// file: verification/blink_props.sv
// Port checker for the alternating indicator blinker
`timescale 1ns/1ps
module blink_props #(
  parameter int unsigned TIMER_DIV      = 4,
  parameter int unsigned FILTER_DIV     = 4,
  parameter int unsigned INTERVAL_TICKS = 5
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic user_switch,
  input wire logic first_indicator,
  input wire logic second_indicator,
  input wire logic manual_mode,
  input wire logic auto_mode
);
  int unsigned gap;
  logic        seen;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence quiet_s; !$changed(first_indicator)[*8]; endsequence
  // Edges since the last swap, valid once one swap was seen
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gap  <= 0;
      seen <= 1'h0;
    end else begin
      gap  <= $changed(first_indicator) ? 1 : gap + 1;
      seen <= seen | $changed(first_indicator);
    end
  end
  excl_mode_a: assert property (!(manual_mode && auto_mode)) else $error("both modes");
  mode_pick_a: assert property (!manual_mode && !auto_mode |=> manual_mode == !$past(user_switch)
    && auto_mode == $past(user_switch)) else $error("wrong mode");
  mode_hold_a: assert property (manual_mode || auto_mode |=> $stable({manual_mode, auto_mode}))
    else $error("mode moved");
  idle_leds_a: assert property (!manual_mode && !auto_mode |-> first_indicator && !second_indicator)
    else $error("idle leds");
  leds_oppose_a: assert property (first_indicator != second_indicator) else $error("leds equal");
  auto_period_a: assert property (auto_mode && seen && $changed(first_indicator) |-> gap == TIMER_DIV * INTERVAL_TICKS)
    else $error("bad period");
  press_cause_a: assert property (manual_mode && $changed(first_indicator) |-> !$past(user_switch, 4))
    else $error("no press");
  press_gap_a: assert property (manual_mode && $changed(first_indicator) |=> quiet_s)
    else $error("bounce swap");
endmodule
bind led_alternate_blinker blink_props #(.TIMER_DIV(TIMER_DIV), .FILTER_DIV(FILTER_DIV),
  .INTERVAL_TICKS(INTERVAL_TICKS)) i_blink_props (.sys_clk(sys_clk), .rstn(rstn),
  .user_switch(user_switch), .first_indicator(first_indicator), .second_indicator(second_indicator),
  .manual_mode(manual_mode), .auto_mode(auto_mode));

// file: verification/push_switch_model.sv
// Push switch with pull-up that drives the switch input
`timescale 1ns/1ps
module push_switch_model (
  input  wire logic sys_clk,
  output logic      user_switch
);
  initial user_switch = led_blink_pkg::SWITCH_RELEASED;
  task automatic hold(input logic lvl, input int n);
    @(posedge sys_clk);
    #1 user_switch = lvl;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
endmodule

// file: verification/led_alternate_blinker_bench.sv
// Self-checking bench for the alternating indicator blinker
`timescale 1ns/1ps
module led_alternate_blinker_bench;
  logic sys_clk;
  logic rstn = 1'h0;
  logic user_switch;
  logic first_indicator;
  logic second_indicator;
  logic manual_mode;
  logic auto_mode;
  int   miscompares = 0;
  int   total_checks = 0;
  led_alternate_blinker #(.TIMER_DIV(4), .FILTER_DIV(4), .INTERVAL_TICKS(5)) i_led_alternate_blinker (
    .sys_clk(sys_clk), .rstn(rstn), .user_switch(user_switch), .first_indicator(first_indicator),
    .second_indicator(second_indicator), .manual_mode(manual_mode), .auto_mode(auto_mode));
  push_switch_model i_push_switch_model (.sys_clk(sys_clk), .user_switch(user_switch));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic sw);
    rstn = 1'h0;
    i_push_switch_model.hold(sw, 20);
    rstn = 1'h1;
    chk("idle leds", 2'h2, {first_indicator, second_indicator});
    @(posedge sys_clk);
    #1 chk("mode", {!sw, sw}, {manual_mode, auto_mode});
  endtask
  task automatic wait_swap(input int lim, output int n);
    logic f;
    f = first_indicator;
    n = 0;
    while (first_indicator === f && n < lim) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask
  task automatic t_manual;
    int n;
    do_reset(1'h0);
    wait_swap(40, n);
    chk("held press", 40, 32'(n));
    i_push_switch_model.hold(1'h1, 20);
    i_push_switch_model.hold(1'h0, 1);
    i_push_switch_model.hold(1'h1, 1);
    wait_swap(30, n);
    chk("bounce", 30, 32'(n));
    i_push_switch_model.hold(1'h0, 1);
    wait_swap(40, n);
    chk("press swap", 1, 32'(n < 40));
    chk("leds", 2'h1, {first_indicator, second_indicator});
  endtask
  task automatic t_auto;
    int n;
    do_reset(1'h1);
    wait_swap(40, n);
    chk("leds", 2'h1, {first_indicator, second_indicator});
    i_push_switch_model.hold(1'h0, 1);
    wait_swap(40, n);
    chk("gap pressed", 20, 32'(n + 2));
    i_push_switch_model.hold(1'h1, 1);
    wait_swap(40, n);
    chk("gap", 20, 32'(n + 2));
    chk("leds", 2'h1, {first_indicator, second_indicator});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #50000;
    miscompares++;
    results();
  end
  initial begin
    t_manual();
    t_auto();
    results();
  end
endmodule
